// ---- pkg/pulse_gear_regs.vh ----
// Purpose: Register map, field positions, reset values and mode codes of the
//          reference pulse front end with electronic gear.
// Assumes: 32-bit AHB-Lite data, one aligned word per register.
// Notes:   Definitions only.
`ifndef PULSE_GEAR_REGS_VH
`define PULSE_GEAR_REGS_VH

// Register byte offsets.
`define REG_CFG 8'h00
`define REG_NUM_FIRST 8'h04
`define REG_DEN 8'h08
`define REG_NUM_SECOND 8'h0c
`define REG_CTRL 8'h10
`define REG_STATUS 8'h14
`define REG_ERROR 8'h18
`define REG_REF_COUNT 8'h1c

// Configuration word fields.
`define CFG_FORM_LSB 0
`define CFG_FORM_MSB 2
`define CFG_CLR_LSB 4
`define CFG_CLR_MSB 5
`define CFG_SW_EN_BIT 8
`define CFG_SW_SEQ_BIT 9

// Control word: restart strobe.
`define CTRL_RESTART_BIT 0

// Status word fields.
`define STAT_LOOP_BIT 0
`define STAT_GEAR2_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_FORM_LSB 4
`define STAT_CLR_LSB 8

// Pulse form codes.
`define FORM_SIGN_PULSE 3'h0
`define FORM_CW_CCW 3'h1
`define FORM_QUAD_X1 3'h2
`define FORM_QUAD_X2 3'h3
`define FORM_QUAD_X4 3'h4

// Clear mode codes.
`define CLR_ON_SERVO_OFF 2'h0
`define CLR_NEVER 2'h1
`define CLR_ON_OFF_OR_OT 2'h2

// Reset values.
`define GEAR_RESET 17'h00001
`define FORM_RESET 3'h0
`define CLR_RESET 2'h0

// Accepted reference rates in pulses per second, and the clock rate.
`define CLK_HZ 20000000
`define MAX_PPS_X1 500000
`define MAX_PPS_X2 400000
`define MAX_PPS_X4 200000
// Least clock cycles between counted edges at x4, rounded down.
`define MIN_EDGE_CYCLES ((`CLK_HZ) / (`MAX_PPS_X4 * 4))

`endif

// ---- rtl/gear_divider.v ----
// Purpose: Scales one reference edge by numerator over denominator, keeping
//          the remainder so that no fraction of a count is lost unless abort clears it.
// Assumes: den is at least one; start only while busy is low.
// Notes:   Restoring division, one quotient bit per clock.
`timescale 1ns/10ps
module gear_divider #(
	parameter W = 17
) (
	input wire hclk,
	input wire hresetn,
	input wire start,
	input wire dir_in,
	input wire abort,
	input wire [W-1:0] num,
	input wire [W-1:0] den,
	output reg busy,
	output reg done,
	output reg dir_out,
	output reg [W-1:0] quotient
);

	localparam CW = 5;
	localparam [CW-1:0] STEPS = W + 1;

	reg [W-1:0] rem;
	reg [W:0] dividend;
	reg [W:0] quo;
	reg [CW-1:0] cnt;
	wire [W:0] trial;
	wire fits;

	// Partial remainder shifted left with the next dividend bit.
	assign trial = {rem, dividend[W]};
	assign fits = (trial >= {1'b0, den});

	// Division sequencer; abort drops the work and the kept fraction.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy <= 1'b0;
			done <= 1'b0;
			dir_out <= 1'b0;
			quotient <= {W{1'b0}};
			rem <= {W{1'b0}};
			dividend <= {(W+1){1'b0}};
			quo <= {(W+1){1'b0}};
			cnt <= {CW{1'b0}};
		end else if (abort) begin
			busy <= 1'b0;
			done <= 1'b0;
			rem <= {W{1'b0}};
		end else if (start && !busy) begin
			busy <= 1'b1;
			done <= 1'b0;
			dir_out <= dir_in;
			dividend <= {1'b0, rem} + {1'b0, num};
			rem <= {W{1'b0}};
			quo <= {(W+1){1'b0}};
			cnt <= STEPS;
		end else if (busy) begin
			dividend <= {dividend[W-1:0], 1'b0};
			if (fits) begin
				rem <= trial[W-1:0] - den;
			end else begin
				rem <= trial[W-1:0];
			end
			quo <= {quo[W-1:0], fits};
			cnt <= cnt - 1'b1;
			if (cnt == 5'h01) begin
				busy <= 1'b0;
				done <= 1'b1;
				quotient <= {quo[W-2:0], fits};
			end
		end else begin
			done <= 1'b0;
		end
	end

endmodule // gear_divider

// ---- rtl/pulse_gear_front_end.v ----
// Purpose: Reference pulse front end of a servo drive: decodes the pulse
//          train, scales it by the electronic gear and keeps the position
//          error counter, with AHB-Lite register access.
// Assumes: All pins synchronous to hclk; one AHB-Lite master.
// Notes:   Settings are shadowed and take effect at reset or restart.
// Summary of operation
// - Quadrature at x1 is counted correctly up to 500 kpps and the host test runs at that rate.
// - Quadrature at x2 is accepted up to 400 kpps and at x4 up to 200 kpps before multiplying.
// - The quadrature multiplier comes only from the pulse form field.
// - Pulse form 0 is sign and pulse, 1 is CW and CCW, 2, 3 and 4 quadrature x1, x2, x4, applied on restart.
// - While error_clear_n is low the position error counter is held at zero.
// - While error_clear_n is low the position loop is disabled.
// - Clear mode 0 zeroes the error on servo-off but not on over-travel.
// - Clear mode 1 never zeroes the error automatically.
// - Clear mode 2 zeroes the error on servo-off or over-travel unless zero clamp is active.
// - Every reference edge is scaled by numerator over denominator into encoder counts.
// - Both numerators and the denominator hold 1 to 100000, reset to 1 and apply on restart; the code keeps any 17-bit value and takes a zero as one.
// - gear_select_n low selects the second numerator, high the first.
// - Numerator switching works only when enabled, timed by the switching sequence setting.
// - Error gathered during servo-off stays pending unless the clear mode discards it.
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "pulse_gear_regs.vh"
module pulse_gear_front_end #(
	parameter GW = 17,
	parameter EW = 32
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire ref_a,
	input wire ref_b,
	input wire error_clear_n,
	input wire gear_select_n,
	input wire servo_on,
	input wire over_travel,
	input wire zero_clamp,
	input wire fb_step,
	input wire fb_dir,
	output reg [EW-1:0] position_error,
	output reg pos_loop_en
);

	// Shadow settings written by software.
	reg [2:0] sh_form;
	reg [1:0] sh_clr;
	reg sh_sw_en;
	reg sh_sw_seq;
	reg [GW-1:0] sh_num1;
	reg [GW-1:0] sh_den;
	reg [GW-1:0] sh_num2;
	// Settings in force since the last restart.
	reg [2:0] pulse_form_sel;
	reg [1:0] clear_mode_sel;
	reg gear_switch_en;
	reg gear_switch_seq_sel;
	reg [GW-1:0] gear_num_first;
	reg [GW-1:0] gear_den;
	reg [GW-1:0] gear_num_second;
	reg use_second;
	reg restart;
	// Bus data phase state.
	reg wr_pend;
	reg [7:0] wr_addr;
	// Decoder state.
	reg a_q;
	reg b_q;
	reg [7:0] pending;
	reg [EW-1:0] ref_count;
	reg [EW-1:0] err;
	// Combinational decoder results.
	reg ev;
	reg ev_dir;

	wire a_rise = ref_a & ~a_q;
	wire a_fall = ~ref_a & a_q;
	wire b_rise = ref_b & ~b_q;
	wire b_fall = ~ref_b & b_q;
	wire addr_phase = hsel & htrans[1] & hready;
	wire div_busy;
	wire div_done;
	wire div_dir;
	wire [GW-1:0] div_q;
	wire pend_zero = (pending == 8'h00);
	wire start_div = !pend_zero && !div_busy && !div_done;
	wire start_dir = ~pending[7];
	wire hold_clear;
	wire [GW-1:0] num_active = use_second ? gear_num_second : gear_num_first;

	// hold at zero on the clear pin.
	// mode 0 clears on servo-off only.
	// mode 1 never clears by itself.
	// mode 2 clears on servo-off or over-travel without zero clamp.
	assign hold_clear = !error_clear_n || restart
		|| (clear_mode_sel == `CLR_ON_SERVO_OFF && !servo_on)
		|| (clear_mode_sel == `CLR_ON_OFF_OR_OT && !zero_clamp
			&& (!servo_on || over_travel));

	// AHB-Lite slave: zero wait states, OKAY always, read data registered.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= addr_phase & hwrite;
			wr_addr <= haddr[7:0];
			if (addr_phase && !hwrite) begin
				case (haddr[7:0])
					`REG_CFG: hrdata <= {22'h000000, sh_sw_seq, sh_sw_en, 2'h0, sh_clr, 1'b0,
						sh_form};
					`REG_NUM_FIRST: hrdata <= {15'h0000, sh_num1};
					`REG_DEN: hrdata <= {15'h0000, sh_den};
					`REG_NUM_SECOND: hrdata <= {15'h0000, sh_num2};
					`REG_STATUS: hrdata <= {22'h000000, clear_mode_sel, 1'b0, pulse_form_sel,
						1'b0, div_busy, use_second, pos_loop_en};
					`REG_ERROR: hrdata <= position_error;
					`REG_REF_COUNT: hrdata <= ref_count;
					default: hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Shadow register writes and the restart strobe.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_form <= `FORM_RESET;
			sh_clr <= `CLR_RESET;
			sh_sw_en <= 1'b0;
			sh_sw_seq <= 1'b0;
			sh_num1 <= `GEAR_RESET;
			sh_den <= `GEAR_RESET;
			sh_num2 <= `GEAR_RESET;
			restart <= 1'b0;
		end else begin
			restart <= 1'b0;
			if (wr_pend) begin
				case (wr_addr)
					`REG_CFG: begin
						sh_form <= hwdata[`CFG_FORM_MSB:`CFG_FORM_LSB];
						sh_clr <= hwdata[`CFG_CLR_MSB:`CFG_CLR_LSB];
						sh_sw_en <= hwdata[`CFG_SW_EN_BIT];
						sh_sw_seq <= hwdata[`CFG_SW_SEQ_BIT];
					end
					`REG_NUM_FIRST: sh_num1 <= hwdata[GW-1:0];
					`REG_DEN: sh_den <= hwdata[GW-1:0];
					`REG_NUM_SECOND: sh_num2 <= hwdata[GW-1:0];
					`REG_CTRL: restart <= hwdata[`CTRL_RESTART_BIT];
					default: restart <= 1'b0;
				endcase
			end
		end
	end

	// settings in force change only at reset or restart.
	// gear values reset to one; a zero is taken as one.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_form_sel <= `FORM_RESET;
			clear_mode_sel <= `CLR_RESET;
			gear_switch_en <= 1'b0;
			gear_switch_seq_sel <= 1'b0;
			gear_num_first <= `GEAR_RESET;
			gear_den <= `GEAR_RESET;
			gear_num_second <= `GEAR_RESET;
		end else if (restart) begin
			pulse_form_sel <= sh_form;
			clear_mode_sel <= sh_clr;
			gear_switch_en <= sh_sw_en;
			gear_switch_seq_sel <= sh_sw_seq;
			gear_num_first <= (sh_num1 == 17'h00000) ? `GEAR_RESET : sh_num1;
			gear_den <= (sh_den == 17'h00000) ? `GEAR_RESET : sh_den;
			gear_num_second <= (sh_num2 == 17'h00000) ? `GEAR_RESET : sh_num2;
		end
	end

	// the multiplier is taken from the pulse form alone.
	// direction from the leading phase, one, two or four edges per cycle.
	always @* begin
		ev = 1'b0;
		ev_dir = 1'b0;
		case (pulse_form_sel)
			`FORM_SIGN_PULSE: begin
				ev = a_rise;
				ev_dir = ref_b;
			end
			`FORM_CW_CCW: begin
				ev = a_rise ^ b_rise;
				ev_dir = a_rise;
			end
			`FORM_QUAD_X1: begin
				ev = a_rise;
				ev_dir = ~ref_b;
			end
			`FORM_QUAD_X2: begin
				ev = a_rise | a_fall;
				ev_dir = ref_a ^ ref_b;
			end
			`FORM_QUAD_X4: begin
				ev = a_rise | a_fall | b_rise | b_fall;
				ev_dir = (a_rise | a_fall) ? (ref_a ^ ref_b) : ~(ref_a ^ ref_b);
			end
			default: begin
				ev = 1'b0;
				ev_dir = 1'b0;
			end
		endcase
	end

	// edges queue in a signed backlog so a burst at the top rate is not lost.
	// the backlog absorbs the division time at the x2 and x4 limits.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_q <= 1'b0;
			b_q <= 1'b0;
			pending <= 8'h00;
			ref_count <= 32'h00000000;
		end else begin
			a_q <= ref_a;
			b_q <= ref_b;
			if (ev) begin
				ref_count <= ev_dir ? ref_count + 32'h00000001 : ref_count - 32'h00000001;
			end
			if (hold_clear) begin
				pending <= 8'h00;
			end else begin
				pending <= pending + (ev ? (ev_dir ? 8'h01 : 8'hff) : 8'h00)
					- (start_div ? (start_dir ? 8'h01 : 8'hff) : 8'h00);
			end
		end
	end

	// only when enabled; sequence 1 waits for standstill with no error.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			use_second <= 1'b0;
		end else if (!gear_switch_en) begin
			use_second <= 1'b0;
		end else if (!gear_switch_seq_sel || (pend_zero && !div_busy && err == 32'h00000000)) begin
			use_second <= ~gear_select_n;
		end
	end

	// each edge is scaled by the active ratio, fraction carried over.
	gear_divider #(
		.W(GW)
	) u_div (
		.hclk(hclk),
		.hresetn(hresetn),
		.start(start_div),
		.dir_in(start_dir),
		.abort(hold_clear),
		.num(num_active),
		.den(gear_den),
		.busy(div_busy),
		.done(div_done),
		.dir_out(div_dir),
		.quotient(div_q)
	);

	// the error keeps accumulating during servo-off unless a clear applies.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err <= 32'h00000000;
		end else if (hold_clear) begin
			err <= 32'h00000000;
		end else begin
			err <= err + (div_done ? (div_dir ? {15'h0000, div_q} : -{15'h0000, div_q})
				: 32'h00000000) - (fb_step ? (fb_dir ? 32'h00000001 : 32'hffffffff)
				: 32'h00000000);
		end
	end

	// the loop is disabled while the clear pin is low.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			position_error <= 32'h00000000;
			pos_loop_en <= 1'b0;
		end else begin
			position_error <= err;
			pos_loop_en <= error_clear_n & servo_on;
		end
	end

endmodule // pulse_gear_front_end

// ---- tb/pulse_gear_props.sv ----
// Purpose: Port checks of the reference pulse front end.
// Assumes: Only the top-level ports are visible.
// Notes: Bound into every instance of the front end.
`timescale 1ns/10ps
module pulse_gear_props #(
	parameter EW = 32
) (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire hready,
	input wire [31:0] hrdata,
	input wire hreadyout,
	input wire hresp,
	input wire error_clear_n,
	input wire servo_on,
	input wire [EW-1:0] position_error,
	input wire pos_loop_en
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_clear_held;
		!error_clear_n ##1 !error_clear_n;
	endsequence
	property p_ready_high;
		hreadyout;
	endproperty
	property p_resp_okay;
		!hresp;
	endproperty
	property p_rdata_hold;
		!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
	endproperty
	property p_loop_change;
		pos_loop_en != $past(pos_loop_en) |-> pos_loop_en == ($past(error_clear_n) && $past(servo_on));
	endproperty
	property p_loop_off;
		!error_clear_n |=> !pos_loop_en;
	endproperty
	property p_loop_servo;
		pos_loop_en |-> $past(servo_on);
	endproperty
	property p_clear_zero;
		s_clear_held |=> position_error == {EW{1'b0}};
	endproperty
	property p_clear_hold;
		s_clear_held ##1 !error_clear_n |=> $stable(position_error);
	endproperty
	a_ready_high: assert property (p_ready_high) else $error("hreadyout dropped");
	a_resp_okay: assert property (p_resp_okay) else $error("hresp not okay");
	a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved without read");
	a_loop_change: assert property (p_loop_change) else $error("loop enable wrong");
	a_loop_off: assert property (p_loop_off) else $error("loop on during clear");
	a_loop_servo: assert property (p_loop_servo) else $error("loop on at servo off");
	a_clear_zero: assert property (p_clear_zero) else $error("error not zero in clear");
	a_clear_hold: assert property (p_clear_hold) else $error("error moved in clear");
endmodule // pulse_gear_props
bind pulse_gear_front_end pulse_gear_props #(.EW(EW)) u_props (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .error_clear_n(error_clear_n),
	.servo_on(servo_on), .position_error(position_error), .pos_loop_en(pos_loop_en));

// ---- tb/ref_host.sv ----
// Purpose: Host controller model sending reference pulse trains.
// Assumes: One move per go pulse, given while busy is low.
// Notes: In pulse mode ref_b carries the sign, set before the first pulse.
`timescale 1ns/10ps
module ref_host (
	input wire hclk,
	input wire go,
	input wire quad,
	input wire dir,
	input wire [3:0] n,
	input wire [5:0] sp,
	output reg ref_a = 1'b0,
	output reg ref_b = 1'b0,
	output reg busy = 1'b0
);
	reg [1:0] ph = 2'h0;
	integer i;
	// edge spacing: sp cycles per phase step sets the rate.
	always @(posedge hclk) begin
		if (go) begin
			busy <= 1'b1;
			if (!quad) ref_b <= dir;
			repeat (sp) @(posedge hclk);
			for (i = 0; i < n * (quad ? 4 : 2); i = i + 1) begin
				if (quad) ph = dir ? ph + 2'h1 : ph - 2'h1;
				ref_a <= quad ? ph[1] ^ ph[0] : ~i[0];
				if (quad) ref_b <= ph[1];
				repeat (sp) @(posedge hclk);
			end
			busy <= 1'b0;
		end
	end
endmodule // ref_host

// ---- tb/tb.sv ----
// Purpose: Self-checking bench of the reference pulse front end.
// Assumes: hready is looped back from hreadyout.
// Notes: One task per test; the error counter is read at its port.
`timescale 1ns/10ps
`include "pulse_gear_regs.vh"
module tb;
	reg hclk = 1'b0;
	reg hresetn = 1'b0;
	reg hsel = 1'b0;
	reg [31:0] haddr = 32'h0;
	reg [1:0] htrans = 2'h0;
	reg hwrite = 1'b0;
	reg [31:0] hwdata = 32'h0;
	reg error_clear_n = 1'b1;
	reg gear_select_n = 1'b1;
	reg servo_on = 1'b1;
	reg over_travel = 1'b0;
	reg zero_clamp = 1'b0;
	reg fb_step = 1'b0;
	reg go = 1'b0;
	reg quad = 1'b0;
	reg dir = 1'b1;
	reg [3:0] n = 4'h0;
	reg [5:0] sp = 6'h1e;
	reg fb_dir = 1'b1;
	wire [31:0] hrdata;
	wire [31:0] position_error;
	wire hreadyout, hresp, ref_a, ref_b, busy, pos_loop_en;
	reg [31:0] rd;
	reg [31:0] c0;
	integer err_total = 0;
	integer tests_run = 0;
	integer cyc = 0;
	integer k;
	pulse_gear_front_end DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ref_a(ref_a), .ref_b(ref_b),
		.error_clear_n(error_clear_n), .gear_select_n(gear_select_n), .servo_on(servo_on),
		.over_travel(over_travel), .zero_clamp(zero_clamp), .fb_step(fb_step),
		.fb_dir(fb_dir), .position_error(position_error), .pos_loop_en(pos_loop_en));
	ref_host host (.hclk(hclk), .go(go), .quad(quad), .dir(dir), .n(n), .sp(sp),
		.ref_a(ref_a), .ref_b(ref_b), .busy(busy));
	// Clock of 50 ns and the hang limit.
	always #25 hclk = ~hclk;
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			end_of_test;
		end
	end
	task end_of_test;
		begin
			$display("compares %0d mismatches %0d", tests_run, err_total);
			if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge hclk);
			hsel <= 1'b1;
			haddr <= {24'h000000, a};
			hwrite <= w;
			htrans <= 2'h2;
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			hsel <= 1'b0;
			htrans <= 2'h0;
			hwdata <= d;
			@(posedge hclk);
			while (hreadyout !== 1'b1) @(posedge hclk);
			rd = hrdata;
		end
	endtask
	task setup(input [2:0] f, input [1:0] c, input sw);
		begin
			xfer(1'b1, `REG_CFG, {22'h0, 1'b0, sw, 2'h0, c, 1'b0, f});
			xfer(1'b1, `REG_CTRL, 32'h1);
		end
	endtask
	task mv(input q, input dr, input [3:0] cnt);
		begin
			@(posedge hclk);
			quad <= q;
			dir <= dr;
			n <= cnt;
			go <= 1'b1;
			@(posedge hclk);
			go <= 1'b0;
			@(posedge hclk);
			while (busy === 1'b1) @(posedge hclk);
			repeat (40) @(posedge hclk);
		end
	endtask
	task t_reset;
		begin
			xfer(1'b0, `REG_CFG, 32'h0);
			chk(rd, 32'h0);
			for (k = 1; k < 4; k = k + 1) begin
				xfer(1'b0, {k[5:0], 2'h0}, 32'h0);
				chk(rd, 32'h1);
			end
			xfer(1'b0, 8'h40, 32'h0);
			chk(rd, 32'h0);
			xfer(1'b0, `REG_STATUS, 32'h0);
			chk(rd, 32'h1);
			// a new form waits for restart.
			xfer(1'b1, `REG_CFG, 32'h4);
			xfer(1'b0, `REG_STATUS, 32'h0);
			chk(rd, 32'h1);
			$display("test reset done");
		end
	endtask
	task t_forms;
		begin
			for (k = 2; k < 5; k = k + 1) begin
				setup(k[2:0], `CLR_ON_SERVO_OFF, 1'b0);
				xfer(1'b0, `REG_REF_COUNT, 32'h0);
				c0 = rd;
				mv(1'b1, 1'b1, 4'h2);
				xfer(1'b0, `REG_REF_COUNT, 32'h0);
				chk(rd - c0, 32'h2 << (k - 2));
				chk(position_error, 32'h2 << (k - 2));
			end
			mv(1'b1, 1'b0, 4'h1);
			chk(position_error, 32'h4);
			setup(`FORM_SIGN_PULSE, `CLR_ON_SERVO_OFF, 1'b0);
			mv(1'b0, 1'b1, 4'h3);
			mv(1'b0, 1'b0, 4'h1);
			chk(position_error, 32'h2);
			setup(`FORM_CW_CCW, `CLR_ON_SERVO_OFF, 1'b0);
			mv(1'b0, 1'b0, 4'h2);
			chk(position_error, 32'h2);
			$display("test forms done");
		end
	endtask
	task t_gear;
		begin
			// ratios 3/2 and 5/2 stay in range.
			xfer(1'b1, `REG_NUM_FIRST, 32'h3);
			xfer(1'b1, `REG_DEN, 32'h2);
			xfer(1'b1, `REG_NUM_SECOND, 32'h5);
			setup(`FORM_QUAD_X4, `CLR_ON_SERVO_OFF, 1'b1);
			mv(1'b1, 1'b1, 4'h1);
			chk(position_error, 32'h6);
			gear_select_n <= 1'b0;
			mv(1'b1, 1'b1, 4'h1);
			chk(position_error, 32'h10);
			xfer(1'b0, `REG_STATUS, 32'h0);
			chk(rd, 32'h43);
			setup(`FORM_QUAD_X4, `CLR_ON_SERVO_OFF, 1'b0);
			mv(1'b1, 1'b1, 4'h1);
			chk(position_error, 32'h6);
			gear_select_n <= 1'b1;
			// sequence one: the switch waits for zero error.
			xfer(1'b1, `REG_CFG, 32'h304);
			xfer(1'b1, `REG_CTRL, 32'h1);
			mv(1'b1, 1'b1, 4'h1);
			chk(position_error, 32'h6);
			gear_select_n <= 1'b0;
			repeat (5) @(posedge hclk);
			xfer(1'b0, `REG_STATUS, 32'h0);
			chk(rd, 32'h41);
			fb_step <= 1'b1;
			repeat (6) @(posedge hclk);
			fb_step <= 1'b0;
			repeat (3) @(posedge hclk);
			chk(position_error, 32'h0);
			xfer(1'b0, `REG_STATUS, 32'h0);
			chk(rd, 32'h43);
			gear_select_n <= 1'b1;
			xfer(1'b1, `REG_NUM_FIRST, 32'h186a0);
			xfer(1'b0, `REG_NUM_FIRST, 32'h0);
			chk(rd, 32'h186a0);
			xfer(1'b1, `REG_NUM_FIRST, 32'h1);
			xfer(1'b1, `REG_DEN, 32'h1);
			$display("test gear done");
		end
	endtask
	task t_clear;
		begin
			setup(`FORM_QUAD_X4, `CLR_NEVER, 1'b0);
			mv(1'b1, 1'b1, 4'h1);
			servo_on <= 1'b0;
			over_travel <= 1'b1;
			repeat (5) @(posedge hclk);
			chk(position_error, 32'h4);
			chk({31'h0, pos_loop_en}, 32'h0);
			servo_on <= 1'b1;
			over_travel <= 1'b0;
			fb_step <= 1'b1;
			@(posedge hclk);
			fb_step <= 1'b0;
			repeat (3) @(posedge hclk);
			chk(position_error, 32'h3);
			fb_dir <= 1'b0;
			fb_step <= 1'b1;
			@(posedge hclk);
			fb_step <= 1'b0;
			fb_dir <= 1'b1;
			repeat (3) @(posedge hclk);
			chk(position_error, 32'h4);
			error_clear_n <= 1'b0;
			repeat (3) @(posedge hclk);
			chk(position_error, 32'h0);
			chk({31'h0, pos_loop_en}, 32'h0);
			error_clear_n <= 1'b1;
			setup(`FORM_QUAD_X4, `CLR_ON_SERVO_OFF, 1'b0);
			mv(1'b1, 1'b1, 4'h1);
			over_travel <= 1'b1;
			repeat (5) @(posedge hclk);
			chk(position_error, 32'h4);
			servo_on <= 1'b0;
			repeat (5) @(posedge hclk);
			chk(position_error, 32'h0);
			servo_on <= 1'b1;
			over_travel <= 1'b0;
			setup(`FORM_QUAD_X4, `CLR_ON_OFF_OR_OT, 1'b0);
			mv(1'b1, 1'b1, 4'h1);
			zero_clamp <= 1'b1;
			over_travel <= 1'b1;
			repeat (5) @(posedge hclk);
			chk(position_error, 32'h4);
			zero_clamp <= 1'b0;
			repeat (5) @(posedge hclk);
			chk(position_error, 32'h0);
			over_travel <= 1'b0;
			$display("test clear done");
		end
	endtask
	// Quadrature at the top accepted rate at x1 and x4, and just below it at x2.
	task t_rate;
		begin
			setup(`FORM_QUAD_X1, `CLR_ON_SERVO_OFF, 1'b0);
			sp <= 6'h0a;
			mv(1'b1, 1'b1, 4'h8);
			chk(position_error, 32'h8);
			setup(`FORM_QUAD_X2, `CLR_ON_SERVO_OFF, 1'b0);
			sp <= 6'h0d;
			mv(1'b1, 1'b1, 4'h8);
			chk(position_error, 32'h10);
			setup(`FORM_QUAD_X4, `CLR_ON_SERVO_OFF, 1'b0);
			sp <= 6'h19;
			mv(1'b1, 1'b0, 4'h8);
			chk(position_error, 32'hffffffe0);
			sp <= 6'h1e;
			$display("test rate done");
		end
	endtask
	// Reset for six cycles, then the tests in turn.
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_forms;
		t_gear;
		t_clear;
		t_rate;
		end_of_test;
	end
endmodule // tb
